// ### hdl/gpio_irq_pkg.sv
package gpio_irq_pkg;

  // ==========================================================================
  // sizes
  localparam int PIN_COUNT = 24;
  localparam int CHIP_EVENTS = 8;
  localparam int ADDR_BITS = 8;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] PIN_ENABLE_OFS = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_OFS = 8'h04;
  localparam logic [7:0] PIN_BUFFER_OFS = 8'h08;
  localparam logic [7:0] PIN_DATA_OFS = 8'h0C;
  localparam logic [7:0] PIN_ALT_SELECT_OFS = 8'h10;
  localparam logic [7:0] PIN_IRQ_ENABLE_OFS = 8'h14;
  localparam logic [7:0] PIN_IRQ_POLARITY_OFS = 8'h18;
  localparam logic [7:0] PIN_IRQ_STATUS_OFS = 8'h1C;
  localparam logic [7:0] LAMP_POLARITY_OFS = 8'h20;
  localparam logic [7:0] CHIP_IRQ_ENABLE_OFS = 8'h24;
  localparam logic [7:0] CHIP_IRQ_STATUS_OFS = 8'h28;
  localparam logic [7:0] OUTPUT_CONTROL_OFS = 8'h2C;

  // ==========================================================================
  // fields and reset values
  localparam int OUTCTL_PUSH_PULL_BIT = 0;
  localparam int OUTCTL_POL_INVERT_BIT = 1;
  localparam logic [1:0] OUTCTL_RESET = 2'h0;
  localparam int CHIP_PIN_SUMMARY_BIT = 0;
  localparam logic [23:0] PIN_RESET = 24'h000000;
  localparam logic [23:0] ALT_AVAIL_MASK = 24'hBFFFFF;
  localparam logic [23:0] LAMP_PIN_MASK = 24'h1E7800;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 24
) (
  input wire logic sys_clk,            // system clock
  input wire logic reset,              // synchronous reset, active high
  input wire logic [WIDTH-1:0] asyncIn, // levels from pins
  output logic [WIDTH-1:0] syncOut     // levels after two flops
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;

  sync_t state_r;
  sync_t state_nxt;

  always_comb begin
    state_nxt.first = asyncIn;
    state_nxt.second = state_r.first;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign syncOut = state_r.second;

endmodule
`default_nettype wire

// ### hdl/gpio_and_interrupt_pin_logic.sv
// Behaviour
// [R1] - interrupt pin active when any enabled chip status bit is set
// [R2] - most chip and pin status bits clear when their status register is read
// [R3] - pin summary status bit is read-only, follows enabled pin status bits
// [R4] - status bits set by events regardless of enable bits; pin status bits are only set on pins whose enable bit is set
// [R5] - output control selects open-drain or push-pull interrupt pin, open-drain at reset
// [R6] - polarity invert chooses active high or low, active low at reset
// [R7] - open-drain interrupt pin is always active low
// [R8] - 24 pins, each configured on its own
// [R9] - pin is general purpose only while its enable bit is set
// [R10] - input pins get pull-up, data register reads pin level
// [R11] - per-pin buffer bit picks push-pull or open-drain
// [R12] - open-drain drives low for data 0, releases for data 1
// [R13] - push-pull drives high or low following data bit
// [R14] - output pins drop pull-up, data reads return sampled pin levels
// [R15] - alternate select bits route alternate function onto enabled pin
// [R16] - alternate outputs use buffer bit; lamp open-drain picks source or drain
// [R17] - alternate input pins stay readable and raise pin interrupts
// [R18] - sampled inputs exported for capture and timer clear logic
// [R19] - alternate functions exist on all pins except pin 22
// [R20] - lamp polarity resets to inverse of strapped pin level
// [R21] - enabled pin status bits are ORed into chip summary bit
// [R22] - pin polarity bit 1 sets status on high level, 0 on low
// [R23] - event in the clearing read cycle keeps its status bit set
`timescale 1ns/10ps
`default_nettype none
module gpio_and_interrupt_pin_logic #(
  parameter int PINS = gpio_irq_pkg::PIN_COUNT,
  parameter int EVENTS = gpio_irq_pkg::CHIP_EVENTS
) (
  input wire logic sys_clk,                   // system clock, 10 MHz
  input wire logic reset,                     // synchronous reset, active high
  input wire logic hsel,                      // ahb slave select
  input wire logic [31:0] haddr,              // ahb address
  input wire logic [1:0] htrans,              // ahb transfer type
  input wire logic hwrite,                    // ahb write
  input wire logic [2:0] hsize,               // ahb size, word only
  input wire logic [31:0] hwdata,             // ahb write data
  input wire logic hready,                    // ahb bus ready
  output logic hreadyout,                     // ahb slave ready
  output logic [31:0] hrdata,                 // ahb read data
  output logic [1:0] hresp,                   // ahb response, always okay
  input wire logic [PINS-1:0] pinIn,          // pin levels seen on the pads
  output logic [PINS-1:0] pinOut,             // pin output level
  output logic [PINS-1:0] pinOe,              // pin output enable, high drives
  output logic [PINS-1:0] pinPullUp,          // pin pull-up enable
  input wire logic [PINS-1:0] altOut,         // alternate function output values
  input wire logic [PINS-1:0] altOe,          // alternate function wants to drive
  output logic [PINS-1:0] altLevel,           // sampled pin levels for other logic
  input wire logic [EVENTS-1:1] chipEvent,    // chip interrupt event pulses
  output logic intOut,                        // interrupt pin output level
  output logic intOe                          // interrupt pin output enable
);
  import gpio_irq_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    // configuration and status registers
    logic [PINS-1:0] enable;
    logic [PINS-1:0] direction;
    logic [PINS-1:0] openDrain;
    logic [PINS-1:0] dataOut;
    logic [PINS-1:0] altSelect;
    logic [PINS-1:0] pinIrqEnable;
    logic [PINS-1:0] pinIrqPolarity;
    logic [PINS-1:0] pinIrqStatus;
    logic [PINS-1:0] lampPolarity;
    logic [EVENTS-1:0] chipIrqEnable;
    logic [EVENTS-1:1] chipIrqStatus;
    logic [1:0] outCtl;
    // strap capture after reset
    logic [1:0] strapWait;
    logic strapTaken;
    // bus data phase
    logic dataPhase;
    logic dataWrite;
    logic [ADDR_BITS-1:0] dataAddr;
    logic readWait;
    logic hreadyout;
    logic [31:0] hrdata;
    // registered pad and interrupt drive
    logic [PINS-1:0] pinOut;
    logic [PINS-1:0] pinOe;
    logic [PINS-1:0] pinPullUp;
    logic intOut;
    logic intOe;
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [PINS-1:0] pinLevel;

  // ==========================================================================
  // pin input synchroniser
  pin_sync #(
    .WIDTH(PINS)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .asyncIn(pinIn),
    .syncOut(pinLevel)
  );

  // ==========================================================================
  // next state
  always_comb begin
    logic addrTake;
    logic [PINS-1:0] pinHit;
    logic [PINS-1:0] pinClr;
    logic [EVENTS-1:1] chipClr;
    logic summary;
    logic active;
    logic useAlt;
    logic value;
    logic drives;
    logic [PINS-1:0] wdata;
    logic [31:0] rdata;
    addrTake = 1'b0;
    pinHit = '0;
    pinClr = '0;
    chipClr = '0;
    summary = 1'b0;
    active = 1'b0;
    useAlt = 1'b0;
    value = 1'b0;
    drives = 1'b0;
    wdata = '0;
    rdata = '0;
    state_nxt = state_r;

    // ------------------------------------------------------------------------
    // strap capture once synchronisers hold real pin levels
    if (!state_r.strapTaken) begin
      if (state_r.strapWait == STRAP_SETTLE) begin
        state_nxt.lampPolarity = ~pinLevel & LAMP_PIN_MASK; // [R20]
        state_nxt.strapTaken = 1'b1;
      end else begin
        state_nxt.strapWait = state_r.strapWait + 2'h1;
      end
    end

    // ------------------------------------------------------------------------
    // ahb address phase
    addrTake = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    state_nxt.dataPhase = addrTake;
    if (addrTake) begin
      state_nxt.dataWrite = hwrite;
      state_nxt.dataAddr = haddr[ADDR_BITS-1:0];
      state_nxt.readWait = !hwrite;
      state_nxt.hreadyout = hwrite;
    end else begin
      state_nxt.readWait = 1'b0;
    end

    // ------------------------------------------------------------------------
    // ahb read, one wait state; status clears here
    if (state_r.readWait) begin
      case (state_r.dataAddr)
        PIN_ENABLE_OFS: begin
          rdata[PINS-1:0] = state_r.enable;
        end
        PIN_DIRECTION_OFS: begin
          rdata[PINS-1:0] = state_r.direction;
        end
        PIN_BUFFER_OFS: begin
          rdata[PINS-1:0] = state_r.openDrain;
        end
        PIN_DATA_OFS: begin
          rdata[PINS-1:0] = pinLevel; // [R10] [R14] [R17]
        end
        PIN_ALT_SELECT_OFS: begin
          rdata[PINS-1:0] = state_r.altSelect;
        end
        PIN_IRQ_ENABLE_OFS: begin
          rdata[PINS-1:0] = state_r.pinIrqEnable;
        end
        PIN_IRQ_POLARITY_OFS: begin
          rdata[PINS-1:0] = state_r.pinIrqPolarity;
        end
        PIN_IRQ_STATUS_OFS: begin
          rdata[PINS-1:0] = state_r.pinIrqStatus;
          pinClr = state_r.pinIrqStatus; // [R2]
        end
        LAMP_POLARITY_OFS: begin
          rdata[PINS-1:0] = state_r.lampPolarity;
        end
        CHIP_IRQ_ENABLE_OFS: begin
          rdata[EVENTS-1:0] = state_r.chipIrqEnable;
        end
        CHIP_IRQ_STATUS_OFS: begin
          rdata[EVENTS-1:0] = {state_r.chipIrqStatus,
                               |(state_r.pinIrqStatus & state_r.pinIrqEnable)}; // [R3]
          chipClr = state_r.chipIrqStatus; // [R2]
        end
        OUTPUT_CONTROL_OFS: begin
          rdata[1:0] = state_r.outCtl;
        end
        default: begin
          rdata = '0;
        end
      endcase
      state_nxt.hrdata = rdata;
      state_nxt.hreadyout = 1'b1;
    end

    // ------------------------------------------------------------------------
    // ahb write data phase
    if (state_r.dataPhase && state_r.dataWrite) begin
      wdata = hwdata[PINS-1:0];
      case (state_r.dataAddr)
        PIN_ENABLE_OFS: begin
          state_nxt.enable = wdata; // [R8]
        end
        PIN_DIRECTION_OFS: begin
          state_nxt.direction = wdata;
        end
        PIN_BUFFER_OFS: begin
          state_nxt.openDrain = wdata;
        end
        PIN_DATA_OFS: begin
          state_nxt.dataOut = wdata;
        end
        PIN_ALT_SELECT_OFS: begin
          state_nxt.altSelect = wdata & ALT_AVAIL_MASK; // [R19]
        end
        PIN_IRQ_ENABLE_OFS: begin
          state_nxt.pinIrqEnable = wdata;
        end
        PIN_IRQ_POLARITY_OFS: begin
          state_nxt.pinIrqPolarity = wdata;
        end
        LAMP_POLARITY_OFS: begin
          state_nxt.lampPolarity = wdata & LAMP_PIN_MASK;
        end
        CHIP_IRQ_ENABLE_OFS: begin
          state_nxt.chipIrqEnable = hwdata[EVENTS-1:0];
        end
        OUTPUT_CONTROL_OFS: begin
          state_nxt.outCtl = hwdata[1:0];
        end
        default: begin
          state_nxt.enable = state_nxt.enable;
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // pin interrupt status, level sensitive, set beats clear
    pinHit = ~(pinLevel ^ state_r.pinIrqPolarity) & state_r.enable; // [R22] [R17]
    state_nxt.pinIrqStatus = (state_r.pinIrqStatus & ~pinClr) | pinHit; // [R4] [R23]

    // ------------------------------------------------------------------------
    // chip interrupt status, set beats clear
    state_nxt.chipIrqStatus = (state_r.chipIrqStatus & ~chipClr) | chipEvent; // [R4] [R23]
    summary = |(state_nxt.pinIrqStatus & state_r.pinIrqEnable); // [R21] [R3]
    active = |({state_nxt.chipIrqStatus, summary} & state_r.chipIrqEnable); // [R1]

    // ------------------------------------------------------------------------
    // interrupt pin drive
    if (!state_r.outCtl[OUTCTL_PUSH_PULL_BIT]) begin
      state_nxt.intOut = 1'b0; // [R7] [R5]
      state_nxt.intOe = active;
    end else begin
      state_nxt.intOe = 1'b1; // [R5]
      state_nxt.intOut = state_r.outCtl[OUTCTL_POL_INVERT_BIT] ? active : !active; // [R6]
    end

    // ------------------------------------------------------------------------
    // per-pin drive
    for (int i = 0; i < PINS; i++) begin
      useAlt = state_r.altSelect[i] && ALT_AVAIL_MASK[i]; // [R15] [R19]
      value = useAlt ? altOut[i] : state_r.dataOut[i];
      drives = useAlt ? altOe[i] : state_r.direction[i];
      if (!state_r.enable[i]) begin
        state_nxt.pinOe[i] = 1'b0; // [R9]
        state_nxt.pinOut[i] = 1'b0;
        state_nxt.pinPullUp[i] = 1'b0;
      end else if (!drives) begin
        state_nxt.pinOe[i] = 1'b0;
        state_nxt.pinOut[i] = 1'b0;
        state_nxt.pinPullUp[i] = 1'b1; // [R10]
      end else if (state_r.openDrain[i]) begin // [R11] [R16]
        state_nxt.pinPullUp[i] = 1'b0; // [R14]
        if (useAlt && LAMP_PIN_MASK[i] && state_r.lampPolarity[i]) begin
          state_nxt.pinOut[i] = 1'b1; // [R16]
          state_nxt.pinOe[i] = value;
        end else begin
          state_nxt.pinOut[i] = 1'b0; // [R12]
          state_nxt.pinOe[i] = !value;
        end
      end else begin
        state_nxt.pinPullUp[i] = 1'b0; // [R14]
        state_nxt.pinOe[i] = 1'b1; // [R13]
        state_nxt.pinOut[i] = value;
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= '0;
      state_r.enable <= PIN_RESET;
      state_r.outCtl <= OUTCTL_RESET;
      state_r.hreadyout <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // sampled levels for capture and timer logic
  typedef struct packed {
    logic [PINS-1:0] level;
  } level_t;

  level_t level_r;
  level_t level_nxt;

  always_comb begin
    level_nxt.level = pinLevel; // [R18]
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign hreadyout = state_r.hreadyout;
  assign hrdata = state_r.hrdata;
  assign hresp = HRESP_OKAY;
  assign pinOut = state_r.pinOut;
  assign pinOe = state_r.pinOe;
  assign pinPullUp = state_r.pinPullUp;
  assign altLevel = level_r.level;
  assign intOut = state_r.intOut;
  assign intOe = state_r.intOe;

endmodule
`default_nettype wire

// ### tb/gpio_irq_props.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_irq_props #(
  parameter int PINS = 24
) (
  input wire logic sys_clk, // clock
  input wire logic reset, // sync reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic [31:0] hrdata, // read data
  input wire logic [1:0] hresp, // response
  input wire logic [PINS-1:0] pinIn, // pads
  input wire logic [PINS-1:0] pinOe, // pad enable
  input wire logic [PINS-1:0] pinPullUp, // pull-up
  input wire logic [PINS-1:0] altLevel, // sampled pads
  input wire logic intOut, // irq level
  input wire logic intOe // irq enable
);
  import gpio_irq_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [1:0] up_r;
  logic rdTake;
  assign rdTake = hsel && htrans[1] && hready && !hwrite;
  always_ff @(posedge sys_clk) begin
    if (reset) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  // ==========================================================================
  // bus and pads
  a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  a_read_wait: assert property (rdTake |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_wait_cause: assert property (!hreadyout |-> $past(rdTake)) else $error("stray wait");
  a_data_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("hrdata moved");
  a_pull_drive: assert property ((pinPullUp & pinOe) == '0)
    else $error("pull-up on driven pin");
  a_irq_lowonly: assert property (intOut |-> intOe)
    else $error("irq high while released");
  a_sync_lag: assert property (up_r == 2'h3 |-> altLevel == $past(pinIn, 3))
    else $error("sampled level lag");
  a_reset_idle: assert property (disable iff (1'b0) reset |=> hreadyout && !intOe && pinOe == '0)
    else $error("not idle after reset");
  c_read: cover property (rdTake);
  c_irq: cover property (intOe && !intOut);
  c_drive: cover property (pinOe != '0);
endmodule
bind gpio_and_interrupt_pin_logic gpio_irq_props #(.PINS(PINS)) props_u (
  .sys_clk, .reset, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp,
  .pinIn, .pinOe, .pinPullUp, .altLevel, .intOut, .intOe
);
`default_nettype wire

// ### tb/board_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module board_side_model #(
  parameter int PINS = 24
) (
  input wire logic [PINS-1:0] pinOut, // device level
  input wire logic [PINS-1:0] pinOe, // device drives
  input wire logic [PINS-1:0] extEn, // board drives
  input wire logic [PINS-1:0] extVal, // board level
  output logic [PINS-1:0] pinIn, // resolved pads
  input wire logic intOut, // irq level
  input wire logic intOe, // irq drives
  output logic intLine // resolved irq line
);
  // ==========================================================================
  // pads: device first, then board driver, else board pull-up resistor
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn);
  assign intLine = intOe ? intOut : 1'b1;
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpio_irq_pkg::*;
  localparam logic [23:0] STRAP = 24'h0A5A5A;
  logic sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, intOut, intOe, intLine;
  logic [1:0] htrans = 2'h0, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [23:0] pinIn, pinOut, pinOe, pinPullUp, altLevel;
  logic [23:0] altOut = 24'h0, altOe = 24'h0, extEn = 24'hFFFFFF, extVal = STRAP;
  logic [7:1] chipEvent = 7'h0;
  int miscompares = 0, num_checks = 0;
  always #50 sys_clk = ~sys_clk;
  gpio_and_interrupt_pin_logic dut_u (.sys_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pinIn, .pinOut,
    .pinOe, .pinPullUp, .altOut, .altOe, .altLevel, .chipEvent, .intOut, .intOe);
  board_side_model board_u (.pinOut, .pinOe, .extEn, .extVal, .pinIn, .intOut, .intOe,
    .intLine);
  // ==========================================================================
  // bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(a, 1'b1, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), d & m, e);
  endtask
  task automatic pulse(input logic [7:1] e);
    chipEvent <= e;
    @(posedge sys_clk);
    chipEvent <= 7'h0;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    rc(OUTPUT_CONTROL_OFS, 32'hFFFFFFFF, 32'h0);
    chk("irq pad", {intOe, intOut}, 2'b00);
    rc(LAMP_POLARITY_OFS, 32'hFFFFFFFF, {8'h0, ~STRAP & LAMP_PIN_MASK});
    rc(8'h3C, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_out();
    extEn <= 24'h000100;
    extVal <= 24'h0;
    wr(PIN_ENABLE_OFS, 32'hFFFFFF);
    wr(PIN_DIRECTION_OFS, 32'hFFFFFF);
    wr(PIN_BUFFER_OFS, 32'h00FF00);
    wr(PIN_DATA_OFS, 32'hA5A5A5);
    repeat (5) @(posedge sys_clk);
    chk("oe", pinOe, 24'hFF5AFF);
    chk("drive", pinOut & pinOe, 24'hA500A5);
    chk("pull", pinPullUp, 24'h0);
    rc(PIN_DATA_OFS, 32'hFFFFFF, 32'hA5A4A5);
  endtask
  task automatic t_in();
    extEn <= 24'hFFFFFF;
    extVal <= 24'h3C5A96;
    wr(PIN_ENABLE_OFS, 32'h0000FF);
    wr(PIN_DIRECTION_OFS, 32'h0);
    repeat (5) @(posedge sys_clk);
    chk("pull", pinPullUp, 24'h0000FF);
    chk("oe", pinOe, 24'h0);
    chk("alt level", altLevel, 24'h3C5A96);
    rc(PIN_DATA_OFS, 32'hFF, 32'h96);
  endtask
  task automatic t_pin_irq();
    extVal <= 24'hFFFFFE;
    wr(PIN_ENABLE_OFS, 32'hFFFFFF);
    wr(PIN_IRQ_POLARITY_OFS, 32'h1);
    wr(PIN_IRQ_ENABLE_OFS, 32'h1);
    wr(CHIP_IRQ_ENABLE_OFS, 32'h1);
    repeat (5) @(posedge sys_clk);
    rc(PIN_IRQ_STATUS_OFS, 32'h0, 32'h0);
    rc(PIN_IRQ_STATUS_OFS, 32'hFFFFFF, 32'h0);
    extVal <= 24'hFFFFFD;
    repeat (5) @(posedge sys_clk);
    chk("irq line", intLine, 1'b0);
    rc(CHIP_IRQ_STATUS_OFS, 32'h1, 32'h1);
    rc(CHIP_IRQ_STATUS_OFS, 32'h1, 32'h1);
    extVal <= 24'hFFFFFE;
    repeat (5) @(posedge sys_clk);
    rc(PIN_IRQ_STATUS_OFS, 32'hFFFFFF, 32'h3);
    rc(PIN_IRQ_STATUS_OFS, 32'hFFFFFF, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq line", intLine, 1'b1);
    rc(CHIP_IRQ_STATUS_OFS, 32'h1, 32'h0);
  endtask
  task automatic t_chip();
    logic [1:0] on [4] = '{2'b10, 2'b10, 2'b10, 2'b11};
    logic [1:0] off [4] = '{2'b00, 2'b11, 2'b00, 2'b10};
    wr(CHIP_IRQ_ENABLE_OFS, 32'h04);
    pulse(7'h01);
    repeat (2) @(posedge sys_clk);
    chk("irq masked", {intOe, intOut}, 2'b00);
    pulse(7'h02);
    for (int m = 0; m < 4; m++) begin
      wr(OUTPUT_CONTROL_OFS, m);
      repeat (2) @(posedge sys_clk);
      chk("irq on", {intOe, intOut}, on[m]);
    end
    rc(CHIP_IRQ_STATUS_OFS, 32'hFE, 32'h06);
    for (int m = 0; m < 4; m++) begin
      wr(OUTPUT_CONTROL_OFS, m);
      repeat (2) @(posedge sys_clk);
      chk("irq off", {intOe, intOut}, off[m]);
    end
  endtask
  task automatic t_race();
    chipEvent <= 7'h04;
    rc(CHIP_IRQ_STATUS_OFS, 32'hFE, 32'h08);
    chipEvent <= 7'h0;
    rc(CHIP_IRQ_STATUS_OFS, 32'hFE, 32'h08);
    rc(CHIP_IRQ_STATUS_OFS, 32'hFE, 32'h0);
  endtask
  task automatic t_alt();
    extEn <= 24'h000020;
    extVal <= 24'h0;
    wr(PIN_BUFFER_OFS, 32'h0);
    wr(PIN_ALT_SELECT_OFS, 32'hFFFFFF);
    rc(PIN_ALT_SELECT_OFS, 32'hFFFFFF, 32'hBFFFFF);
    altOe <= 24'h400081;
    altOut <= 24'h400001;
    repeat (3) @(posedge sys_clk);
    chk("alt oe", pinOe, 24'h000081);
    chk("alt drive", pinOut & pinOe, 24'h000001);
    rc(PIN_DATA_OFS, 32'h20, 32'h0);
    wr(PIN_ENABLE_OFS, 32'hFFFF7F);
    repeat (2) @(posedge sys_clk);
    chk("alt off", pinOe, 24'h000001);
    wr(PIN_BUFFER_OFS, 32'h002800);
    altOe <= 24'h402881;
    altOut <= 24'h402801;
    repeat (3) @(posedge sys_clk);
    chk("lamp oe", pinOe & 24'h002800, 24'h002000);
    chk("lamp drive", pinOut & 24'h002800, 24'h002000);
  endtask
  // ==========================================================================
  // run control
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_out();
    t_in();
    t_pin_irq();
    t_chip();
    t_race();
    t_alt();
    end_of_test();
  end
endmodule
`default_nettype wire
